// ---- hw/crtc_defines.svh ----
`ifndef CRTC_DEFINES_SVH
`define CRTC_DEFINES_SVH
// ==========================================================
// Register offsets (byte addresses on APB)
`define OFS_CTRL      8'h00
`define OFS_TOP_PTR   8'h04
`define OFS_HTIM      8'h08
`define OFS_VTIM      8'h0C
`define OFS_STATUS    8'h10
// ==========================================================
// Field positions
`define CTRL_RUN_BIT  0
`define RCB_REDEF_BIT 31
`define RCB_ATTR_BIT  30
`define ATTR_BLINK_BIT 7
// ==========================================================
// Reset values
`define HTIM_RST      24'h0F0C50
`define VTIM_RST      13'h030B
`define TOP_PTR_RST   32'h0000_0000
// ==========================================================
// Sizes and counts
`define ROW_CHARS     7'h40
`define NUM_BUFS      2'h3
`define FIFO_DEPTH    8
`define BLOCK_WORDS   2'h3
`endif

// ---- hw/crtc_pkg.sv ----
package crtc_pkg;
  typedef enum logic [2:0] {
    F_IDLE    = 3'b000,
    F_FRAME   = 3'b001,
    F_RCB     = 3'b010,
    F_WAITBUF = 3'b011,
    F_CHAR    = 3'b100,
    F_ATTR    = 3'b101,
    F_SETTLE  = 3'b110,
    F_ENDCHN  = 3'b111
  } fetch_st_t;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_WAIT = 2'b01,
    D_ROW  = 2'b10,
    D_VRET = 2'b11
  } disp_st_t;

  typedef struct packed {
    logic [1:0] buf_id;
    logic       is_attr;
    logic [5:0] idx;
    logic [7:0] data;
  } fifo_word_t;

  typedef struct packed {
    logic [9:0] row_attr;
    logic [6:0] vis;
    logic [6:0] hid;
    logic       attr_inv;
    logic       last;
  } row_meta_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic       hsync;
    logic       vsync;
    logic       blank;
    logic       cursor;
    logic [7:0] char_attr;
    logic [9:0] row_attr;
    logic [4:0] scan_line_index;
    logic [7:0] glyph_code_out;
  } video_out_t;
endpackage

// ---- hw/crtc_row_display.sv ----
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "crtc_defines.svh"

// ==========================================================
// Data FIFO
module row_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && !full)
        wr_ptr <= wr_ptr + 1'b1;
      if (out_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (in_valid && !full)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// ==========================================================
// Row buffer display controller
module crtc_row_display (
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output crtc_pkg::mem_req_t         mem,
  input  wire logic                  mem_ack,
  input  wire logic [31:0]           mem_rdata,
  output crtc_pkg::video_out_t       video
);
  import crtc_pkg::*;

  typedef struct packed {
    logic        act;
    logic        inact;
    logic        retrace;
    logic        hsync;
    logic        vsync;
    logic        cursor;
    logic        attr_inv;
    logic        blink_on;
    logic [4:0]  line;
    logic [9:0]  rattr;
  } stage_t;

  typedef struct packed {
    logic          run;
    logic [2:0]    cfg;
    logic [31:0]   top_ptr;
    logic [23:0]   htim;
    logic [12:0]   vtim;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    fetch_st_t     fst;
    logic [31:0]   fptr;
    logic [1:0]    wcnt;
    logic [31:0]   rcb_next;
    logic [31:0]   cptr;
    logic [31:0]   aptr;
    logic [31:0]   rcb_ctl;
    logic [5:0]    idx;
    logic [1:0]    fill_buf;
    logic [3:0]    scroll;
    logic [3:0]    cb_rate;
    logic [3:0]    cb_duty;
    logic [3:0]    kb_rate;
    logic [3:0]    kb_duty;
    logic [6:0]    cur_x;
    logic [7:0]    cur_y;
    logic [7:0]    fill;
    logic [9:0]    cur_rattr;
    logic [2:0]    valid;
    row_meta_t [2:0] meta;
    mem_req_t      mem;
    disp_st_t      dst;
    logic [1:0]    disp_buf;
    logic [7:0]    h;
    logic [4:0]    line;
    logic [4:0]    vline;
    logic [7:0]    row_no;
    logic [3:0]    cb_cnt;
    logic [3:0]    kb_cnt;
    stage_t        s1;
    video_out_t    video;
  } state_t;

  state_t     s;
  state_t     next_s;
  fifo_word_t fifo_in;
  fifo_word_t fifo_out;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] char_mem [0:191];
  logic [7:0] attr_mem [0:191];
  logic [7:0] rd_char;
  logic [7:0] rd_attr;
  logic [7:0] rd_idx;
  logic       apb_wr;
  logic       mem_done;
  logic       showing;
  logic [6:0] vis_clamp;
  logic [7:0] act_len;
  logic [1:0] buf_inc;
  logic [1:0] fill_inc;
  row_meta_t  dmeta;

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign mem     = s.mem;
  assign video   = s.video;

  // ========================================================
  // Data path FIFO between DMA and row buffers
  assign fifo_in_valid  = mem_done && (s.fst == F_CHAR || s.fst == F_ATTR);
  assign fifo_in.buf_id  = s.fill_buf;
  assign fifo_in.is_attr = (s.fst == F_ATTR);
  assign fifo_in.idx     = s.idx;
  assign fifo_in.data    = mem_rdata[7:0];
  // Drain stalls rather than touch the buffer on screen
  assign fifo_out_ready = !(showing && fifo_out.buf_id == s.disp_buf);

  row_fifo #(
    .WIDTH ($bits(fifo_word_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // ========================================================
  // Row buffer storage
  assign rd_idx = {s.disp_buf, s.h[5:0]};

  always_ff @(posedge sys_clk)
  begin
    if (fifo_out_valid && fifo_out_ready)
    begin
      if (fifo_out.is_attr)
        attr_mem[{fifo_out.buf_id, fifo_out.idx}] <= fifo_out.data;
      else
        char_mem[{fifo_out.buf_id, fifo_out.idx}] <= fifo_out.data;
    end
    rd_char <= char_mem[rd_idx];
    rd_attr <= attr_mem[rd_idx];
  end

  // ========================================================
  // Next state
  always_comb
  begin
    next_s    = s;
    apb_wr    = psel && penable && s.pready && pwrite;
    mem_done  = s.mem.req && mem_ack;
    showing   = (s.dst == D_ROW);
    vis_clamp = (s.rcb_ctl[6:0] > `ROW_CHARS) ? `ROW_CHARS : s.rcb_ctl[6:0];
    dmeta     = s.meta[s.disp_buf];
    act_len   = {1'b0, dmeta.vis} + {1'b0, dmeta.hid};
    buf_inc   = (s.disp_buf == `NUM_BUFS - 2'h1) ? 2'h0 : s.disp_buf + 2'h1;
    fill_inc  = (s.fill_buf == `NUM_BUFS - 2'h1) ? 2'h0 : s.fill_buf + 2'h1;

    // APB: answer in the first access cycle
    next_s.pready  = psel && !penable;
    next_s.pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        `OFS_CTRL:    next_s.prdata = {31'h0000_0000, s.run};
        `OFS_TOP_PTR: next_s.prdata = s.top_ptr;
        `OFS_HTIM:    next_s.prdata = {8'h00, s.htim};
        `OFS_VTIM:    next_s.prdata = {19'h00000, s.vtim};
        `OFS_STATUS:  next_s.prdata = {s.row_no, 4'h0, s.scroll, s.fill_buf, s.disp_buf,
                                       1'b0, s.valid, 2'h0, s.dst, 1'b0, s.fst};
        default:      next_s.pslverr = 1'b1;
      endcase
    end
    if (apb_wr)
    begin
      unique case (paddr)
        `OFS_CTRL:
        begin
          // Start is refused until every setup register was written
          next_s.run = pwdata[`CTRL_RUN_BIT] && (s.cfg == 3'h7);
        end
        `OFS_TOP_PTR:
        begin
          next_s.top_ptr = pwdata;
          next_s.cfg[0]  = 1'b1;
        end
        `OFS_HTIM:
        begin
          next_s.htim   = pwdata[23:0];
          next_s.cfg[1] = 1'b1;
        end
        `OFS_VTIM:
        begin
          next_s.vtim   = pwdata[12:0];
          next_s.cfg[2] = 1'b1;
        end
        default:
        begin
        end
      endcase
    end

    // ======================================================
    // Fetch sequencer
    unique case (s.fst)
      F_IDLE:
      begin
        if (s.run)
        begin
          next_s.fptr = s.top_ptr;
          next_s.wcnt = 2'h0;
          next_s.fst  = F_FRAME;
        end
      end
      F_FRAME, F_RCB:
      begin
        if (!s.mem.req)
        begin
          next_s.mem.req  = 1'b1;
          next_s.mem.addr = s.fptr + {28'h0000000, s.wcnt, 2'b00};
        end
        if (mem_done)
        begin
          next_s.mem.req = 1'b0;
          next_s.wcnt    = s.wcnt + 2'h1;
          if (s.fst == F_FRAME)
          begin
            unique case (s.wcnt)
              2'h0: next_s.rcb_next = mem_rdata;
              2'h1:
              begin
                next_s.scroll  = mem_rdata[3:0];
                next_s.cb_rate = mem_rdata[7:4];
                next_s.cb_duty = mem_rdata[11:8];
                next_s.kb_rate = mem_rdata[15:12];
                next_s.kb_duty = mem_rdata[19:16];
              end
              2'h2:
              begin
                next_s.cur_x = mem_rdata[6:0];
                next_s.cur_y = mem_rdata[15:8];
              end
              2'h3: next_s.fill = mem_rdata[7:0];
            endcase
          end
          else
          begin
            unique case (s.wcnt)
              2'h0: next_s.rcb_next = mem_rdata;
              2'h1: next_s.cptr     = mem_rdata;
              2'h2: next_s.aptr     = mem_rdata;
              2'h3: next_s.rcb_ctl  = mem_rdata;
            endcase
          end
          if (s.wcnt == `BLOCK_WORDS)
          begin
            next_s.wcnt = 2'h0;
            if (s.fst == F_FRAME)
            begin
              next_s.fptr = s.rcb_next;
              next_s.fst  = (s.rcb_next == 32'h0000_0000) ? F_ENDCHN : F_RCB;
            end
            else
            begin
              if (mem_rdata[`RCB_REDEF_BIT])
                next_s.cur_rattr = mem_rdata[25:16];
              next_s.fst = F_WAITBUF;
            end
          end
        end
      end
      F_WAITBUF:
      begin
        // Target buffer must be empty and off screen before filling
        if (!s.valid[s.fill_buf] && !(showing && s.disp_buf == s.fill_buf))
        begin
          next_s.idx = 6'h00;
          next_s.fst = (vis_clamp == 7'h00) ? F_SETTLE : F_CHAR;
        end
      end
      F_CHAR, F_ATTR:
      begin
        // One word in flight, issued only with FIFO room
        if (!s.mem.req && fifo_in_ready)
        begin
          next_s.mem.req  = 1'b1;
          next_s.mem.addr = ((s.fst == F_CHAR) ? s.cptr : s.aptr) + {24'h000000, s.idx, 2'b00};
        end
        if (mem_done)
        begin
          next_s.mem.req = 1'b0;
          next_s.idx     = s.idx + 6'h01;
          if ({1'b0, s.idx} == vis_clamp - 7'h01)
          begin
            next_s.idx = 6'h00;
            if (s.fst == F_CHAR && s.rcb_ctl[`RCB_ATTR_BIT])
              next_s.fst = F_ATTR;
            else
              next_s.fst = F_SETTLE;
          end
        end
      end
      F_SETTLE:
      begin
        // Buffer counts as loaded only once the FIFO has drained into it
        if (!fifo_out_valid)
        begin
          next_s.valid[s.fill_buf]         = 1'b1;
          next_s.meta[s.fill_buf].row_attr = s.rcb_ctl[`RCB_REDEF_BIT] ?
                                             s.rcb_ctl[25:16] : s.cur_rattr;
          next_s.meta[s.fill_buf].vis      = vis_clamp;
          next_s.meta[s.fill_buf].hid      = s.rcb_ctl[14:8];
          next_s.meta[s.fill_buf].attr_inv = s.rcb_ctl[`RCB_ATTR_BIT];
          next_s.meta[s.fill_buf].last     = (s.rcb_next == 32'h0000_0000);
          next_s.fill_buf                  = fill_inc;
          next_s.fptr                      = s.rcb_next;
          next_s.fst = (s.rcb_next == 32'h0000_0000) ? F_ENDCHN : F_RCB;
        end
      end
      F_ENDCHN:
      begin
        // Frame block is fetched anew for every frame
        if (s.dst == D_VRET || s.dst == D_IDLE)
        begin
          next_s.fptr = s.top_ptr;
          next_s.fst  = F_FRAME;
        end
      end
    endcase

    // ======================================================
    // Display timing
    next_s.s1.act      = showing;
    next_s.s1.inact    = showing && (s.h < {1'b0, dmeta.vis});
    next_s.s1.retrace  = showing && (s.h >= act_len);
    next_s.s1.hsync    = (showing || s.dst == D_VRET) &&
                         (s.h >= s.htim[15:8]) && (s.h < s.htim[23:16]);
    next_s.s1.vsync    = (s.dst == D_VRET);
    next_s.s1.cursor   = showing && (s.row_no == s.cur_y) && (s.h == {1'b0, s.cur_x}) &&
                         (s.kb_cnt >= s.kb_duty);
    next_s.s1.attr_inv = dmeta.attr_inv;
    next_s.s1.blink_on = (s.cb_cnt >= s.cb_duty);
    next_s.s1.line     = s.line;
    next_s.s1.rattr    = dmeta.row_attr;

    unique case (s.dst)
      D_IDLE, D_WAIT:
      begin
        // Start only on a loaded buffer
        if (s.run && s.valid[s.disp_buf])
        begin
          next_s.dst  = D_ROW;
          next_s.h    = 8'h00;
          next_s.line = 5'h00;
        end
      end
      D_ROW:
      begin
        next_s.h = s.h + 8'h01;
        if (s.h == s.htim[7:0])
        begin
          next_s.h = 8'h00;
          if (s.line == s.vtim[4:0])
          begin
            next_s.line              = 5'h00;
            next_s.valid[s.disp_buf] = 1'b0;
            next_s.disp_buf          = buf_inc;
            next_s.row_no            = s.row_no + 8'h01;
            if (dmeta.last)
            begin
              next_s.dst   = D_VRET;
              next_s.vline = 5'h00;
            end
            else if (!s.valid[buf_inc])
              next_s.dst = D_WAIT;
          end
          else
            next_s.line = s.line + 5'h01;
        end
      end
      D_VRET:
      begin
        next_s.h = s.h + 8'h01;
        if (s.h == s.htim[7:0])
        begin
          next_s.h     = 8'h00;
          next_s.vline = s.vline + 5'h01;
          if (s.vline == s.vtim[12:8])
          begin
            next_s.dst    = D_WAIT;
            next_s.row_no = 8'h00;
            next_s.cb_cnt = (s.cb_cnt >= s.cb_rate) ? 4'h0 : s.cb_cnt + 4'h1;
            next_s.kb_cnt = (s.kb_cnt >= s.kb_rate) ? 4'h0 : s.kb_cnt + 4'h1;
          end
        end
      end
    endcase

    // ======================================================
    // Output stage, one cycle behind the buffer read
    next_s.video.hsync           = s.s1.hsync;
    next_s.video.vsync           = s.s1.vsync;
    next_s.video.blank           = !s.s1.inact;
    next_s.video.cursor          = s.s1.cursor;
    next_s.video.scan_line_index = s.s1.line;
    next_s.video.row_attr        = s.s1.retrace ? s.s1.rattr : 10'h000;
    next_s.video.char_attr       = (s.s1.inact && s.s1.attr_inv) ? rd_attr : 8'h00;
    // Blink-off and hidden positions show the fill code
    if (s.s1.inact && !(s.s1.attr_inv && rd_attr[`ATTR_BLINK_BIT] && !s.s1.blink_on))
      next_s.video.glyph_code_out = rd_char;
    else
      next_s.video.glyph_code_out = s.fill;

    // Stop returns both sequencers, the memory request and the row buffers to idle
    if (!s.run)
    begin
      next_s.fst      = F_IDLE;
      next_s.dst      = D_IDLE;
      next_s.mem.req  = 1'b0;
      next_s.valid    = 3'h0;
      next_s.fill_buf = 2'h0;
      next_s.disp_buf = 2'h0;
      next_s.row_no   = 8'h00;
    end
  end

  // ========================================================
  // State register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s         <= '0;
      s.htim    <= `HTIM_RST;
      s.vtim    <= `VTIM_RST;
      s.top_ptr <= `TOP_PTR_RST;
      s.fst     <= F_IDLE;
      s.dst     <= D_IDLE;
      s.video.blank <= 1'b1;
    end
    else
      s <= next_s;
  end
endmodule

// ---- verif/crtc_mem_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Main memory behind the DMA port
module crtc_mem_model (
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire crtc_pkg::mem_req_t mem,
  input  wire logic [3:0]         lat,
  output logic                    mem_ack,
  output logic      [31:0]        mem_rdata
);
  import crtc_pkg::*;
  logic [3:0] cnt;
  // Frame block at 0x100 links to one row block at 0x200
  function automatic logic [31:0] word(input logic [31:0] a);
    case (a)
      32'h0000_0100: word = 32'h0000_0200;
      32'h0000_0104: word = 32'h0000_0000;
      32'h0000_0108: word = 32'h0000_0001;
      32'h0000_010C: word = 32'h0000_0041;
      32'h0000_0200: word = 32'h0000_0000;
      32'h0000_0204: word = 32'h0000_0400;
      32'h0000_0208: word = 32'h0000_0500;
      32'h0000_020C: word = 32'hC2A5_0204;
      default:       word = {24'h0, 8'h30 + {2'h0, a[7:2]}};
    endcase
  endfunction
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_ack   <= 1'h0;
      mem_rdata <= 32'h0;
      cnt       <= 4'h0;
    end
    else
    begin
      mem_ack   <= 1'h0;
      // Stale data flips so it never passes for a valid word
      mem_rdata <= ~mem_rdata;
      if (mem.req && !mem_ack)
      begin
        if (cnt >= lat)
        begin
          mem_ack   <= 1'h1;
          mem_rdata <= word(mem.addr);
          cnt       <= 4'h0;
        end
        else
          cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ---- verif/crtc_row_display_assertions.sv ----
`timescale 1ns/1ps
`include "crtc_defines.svh"
// ==========================================================
// Port checker
module crtc_row_display_assertions (
  input wire logic                  sys_clk,
  input wire logic                  arst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire crtc_pkg::mem_req_t    mem,
  input wire logic                  mem_ack,
  input wire logic [31:0]           mem_rdata,
  input wire crtc_pkg::video_out_t  video
);
  import crtc_pkg::*;
  logic [2:0]  seen;
  logic        started;
  logic [2:0]  idle_cyc;
  logic [3:0]  acks;
  logic [31:0] top_q;
  logic        wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  // Shadow of what software asked for; idle_cyc leaves room for the output lag
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seen     <= 3'h0;
      started  <= 1'h0;
      idle_cyc <= 3'h7;
      acks     <= 4'h0;
      top_q    <= `TOP_PTR_RST;
    end
    else
    begin
      if (wr_ok && paddr == `OFS_TOP_PTR)
      begin
        seen[0] <= 1'h1;
        top_q   <= pwdata;
      end
      if (wr_ok && paddr == `OFS_HTIM)
        seen[1] <= 1'h1;
      if (wr_ok && paddr == `OFS_VTIM)
        seen[2] <= 1'h1;
      if (wr_ok && paddr == `OFS_CTRL)
        started <= pwdata[0] && (&seen);
      idle_cyc <= started ? 3'h0 : ((idle_cyc == 3'h7) ? 3'h7 : idle_cyc + 3'h1);
      if (mem.req && mem_ack && acks != 4'hF)
        acks <= acks + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_no_fetch_idle;
    !started && idle_cyc == 3'h7 |-> !mem.req;
  endproperty
  a_no_fetch_idle: assert property (p_no_fetch_idle) else $error("fetch while idle");
  property p_idle_lines;
    !started && idle_cyc == 3'h7 |-> !video.hsync && !video.vsync && video.blank;
  endproperty
  a_idle_lines: assert property (p_idle_lines) else $error("sync or blank wrong");
  property p_req_drop;
    mem.req && mem_ack |=> !mem.req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after ack");
  property p_req_hold;
    mem.req && !mem_ack && started && !wr_ok |=> mem.req && $stable(mem.addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved before ack");
  property p_apb_wait;
    psel && !penable |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("no ready in access");
  property p_apb_err;
    pready |-> pslverr == !(paddr inside {`OFS_CTRL, `OFS_TOP_PTR, `OFS_HTIM, `OFS_VTIM,
                                          `OFS_STATUS});
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("error response wrong");
  property p_top_read;
    pready && !pwrite && paddr == `OFS_TOP_PTR |-> prdata == top_q;
  endproperty
  a_top_read: assert property (p_top_read) else $error("page pointer readback");
  property p_retrace_blank;
    video.row_attr != 10'h0 |-> video.blank;
  endproperty
  a_retrace_blank: assert property (p_retrace_blank) else $error("row code unblanked");
  property p_first_frame;
    !video.blank |-> acks >= 4'h8;
  endproperty
  a_first_frame: assert property (p_first_frame) else $error("beam on before load");
  c_start: cover property (started && mem.req);
  c_retrace: cover property (video.row_attr != 10'h0);
  c_err: cover property (pready && pslverr);
endmodule

bind crtc_row_display crtc_row_display_assertions chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .video(video)
);

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`include "crtc_defines.svh"
`define CHK(nm, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("unexpected %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
// ==========================================================
// Bench
module tb_top;
  import crtc_pkg::*;
  logic        sys_clk = 1'h0;
  logic        arst_n, psel, penable, pwrite, pready, pslverr, mem_ack, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mem_rdata, rd;
  logic [3:0]  lat;
  mem_req_t    mem;
  video_out_t  video;
  int          error_cnt = 0;
  int          checks = 0;
  int          n, nb;
  logic        ra;
  logic [31:0] base [4] = '{32'h100, 32'h200, 32'h400, 32'h500};

  always #25 sys_clk = ~sys_clk;

  crtc_row_display uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .video(video)
  );
  crtc_mem_model mem_model (
    .sys_clk(sys_clk), .arst_n(arst_n), .mem(mem), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  task close_out;
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; values read just after an edge are those sampled at it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'h1 && k < 16);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1)
    begin
      error_cnt++;
      close_out();
    end
  endtask

  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, lat} = '0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'h1;
    @(posedge sys_clk);
    `CHK("blank", 1'h1, video.blank)
    `CHK("syncs", 2'h0, {video.hsync, video.vsync})
    apb(1'h0, 8'h14, 32'h0);
    `CHK("unmapped", 1'h1, err)
    apb(1'h0, `OFS_HTIM, 32'h0);
    `CHK("htim", {8'h0, `HTIM_RST}, rd)
    apb(1'h1, `OFS_CTRL, 32'h1);
    apb(1'h0, `OFS_CTRL, 32'h0);
    `CHK("early run", 1'h0, rd[0])
    repeat (20) @(posedge sys_clk);
    `CHK("early req", 1'h0, mem.req)
    apb(1'h1, `OFS_TOP_PTR, 32'h100);
    apb(1'h1, `OFS_HTIM, 32'h000C_0A0F);
    apb(1'h1, `OFS_VTIM, 32'h0000_0103);
    apb(1'h0, `OFS_TOP_PTR, 32'h0);
    `CHK("top ptr", 32'h100, rd)
    apb(1'h1, `OFS_CTRL, 32'h1);
    // Latency varies per word so prompt and slow answers both occur
    for (int i = 0; i < 16; i++)
    begin
      lat <= 4'(i % 4);
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (!(mem_ack === 1'h1 && mem.req === 1'h1) && n < 200);
      // A fetch that never comes is a failure, not a skipped compare
      if (!(mem_ack === 1'h1 && mem.req === 1'h1))
      begin
        error_cnt++;
        close_out();
      end
      `CHK("fetch addr", base[i / 4] + 32'(4 * (i % 4)), mem.addr)
    end
    nb = 0;
    ra = 1'h0;
    for (int k = 0; k < 600; k++)
    begin
      @(posedge sys_clk);
      if (video.blank === 1'h0 && nb < 4)
      begin
        `CHK("glyph", 8'h30 + 8'(nb), video.glyph_code_out)
        `CHK("scan line", 5'h0, video.scan_line_index)
        `CHK("char attr", 8'h30 + 8'(nb), video.char_attr)
        `CHK("cursor", nb == 1, video.cursor)
        nb++;
      end
      if (video.row_attr !== 10'h0 && !ra)
      begin
        `CHK("row attr", 10'h2A5, video.row_attr)
        `CHK("fill", 8'h41, video.glyph_code_out)
        ra = 1'h1;
      end
    end
    `CHK("chars shown", 4, nb)
    `CHK("retrace seen", 1'h1, ra)
    // Stop mid-run: outputs go idle once the two-cycle lag has passed
    apb(1'h1, `OFS_CTRL, 32'h0);
    repeat (4) @(posedge sys_clk);
    `CHK("stop blank", 1'h1, video.blank)
    `CHK("stop syncs", 2'h0, {video.hsync, video.vsync})
    `CHK("stop req", 1'h0, mem.req)
    apb(1'h0, `OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
    close_out();
  end
endmodule
